/* sbrg_top.sv */
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Bit clock comes from system clock; firmware rewrites divisor after clock changes.
// - Receive level is majority of three samples per bit.
// - Async, 8-bit, low speed: rate is clock over 64 times (n+1).
// - Async, 8-bit, high speed: rate is clock over 16 times (n+1).
// - Async, 16-bit, low speed: rate is clock over 16 times (n+1).
// - Synchronous: prescale ignored, rate is clock over 4 times (n+1).
// - Divisor n is high:low pair; in 8-bit mode only low byte counts.
// - Writing either divisor register clears the rate timer at once.
// - Reset gives 8-bit divisor; width select bit 3 picks 16-bit.
module sbrg_top (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        RX_PIN,
    output logic             BIT_TICK,
    output logic             SAMPLE_TICK,
    output logic             RX_LEVEL
);
    logic [7:0]  tx_q, rx_q, rc_q, divh_q, divl_q;
    logic [7:0]  wr_addr_q;
    logic        wr_pend_q;
    logic [31:0] rdata_q;
    logic [15:0] div_cnt_q;
    logic [6:0]  pre_cnt_q;
    logic        bit_tick_q, sample_tick_q;
    logic        rx_s1_q, rx_s2_q;
    logic [1:0]  smp_cnt_q;
    logic        vote_level;

    wire         take     = HSEL & HREADY & HTRANS[1];
    wire         take_wr  = take & HWRITE;
    wire         take_rd  = take & ~HWRITE;
    wire [7:0]   a8       = {HADDR[7:2], 2'b00};
    wire [7:0]   wd       = HWDATA[7:0];
    wire         wr_tx    = wr_pend_q && (wr_addr_q == sbrg_pkg::ADDR_TX_CTRL);
    wire         wr_rx    = wr_pend_q && (wr_addr_q == sbrg_pkg::ADDR_RX_CTRL);
    wire         wr_rc    = wr_pend_q && (wr_addr_q == sbrg_pkg::ADDR_RATE_CTRL);
    wire         wr_dh    = wr_pend_q && (wr_addr_q == sbrg_pkg::ADDR_DIV_HIGH);
    wire         wr_dl    = wr_pend_q && (wr_addr_q == sbrg_pkg::ADDR_DIV_LOW);
    wire         div_wr   = wr_dh | wr_dl;

    wire         sync_md  = tx_q[sbrg_pkg::TX_SYNC_BIT];
    wire         hspeed   = tx_q[sbrg_pkg::TX_HSPEED_BIT];
    wire         wide     = rc_q[sbrg_pkg::RC_WIDTH_BIT];
    wire [15:0]  divisor  = wide ? {divh_q, divl_q} : {8'h00, divl_q};
    wire [6:0]   pre_sel  = sync_md ? sbrg_pkg::PRE_4 :
                            (!wide && !hspeed) ? sbrg_pkg::PRE_64 :
                            (!wide &&  hspeed) ? sbrg_pkg::PRE_16 :
                            (!hspeed) ? sbrg_pkg::PRE_16 :
                            sbrg_pkg::PRE_4;
    wire         pre_end  = (pre_cnt_q == pre_sel - 7'h01) || (pre_cnt_q >= pre_sel);
    wire         div_end  = (div_cnt_q >= divisor);
    wire         run      = rx_q[sbrg_pkg::RX_SPEN_BIT];
    // Samples open at the middle prescale period; a prescale is at least 4 cycles, so three fit
    wire         smp_open = (pre_cnt_q == 7'h00) && (div_cnt_q == {1'b0, divisor[15:1]});
    wire [31:0]  rd_mux   = (a8 == sbrg_pkg::ADDR_TX_CTRL)   ? {24'h0, tx_q}   :
                            (a8 == sbrg_pkg::ADDR_RX_CTRL)   ? {24'h0, rx_q}   :
                            (a8 == sbrg_pkg::ADDR_RATE_CTRL) ? {24'h0, rc_q}   :
                            (a8 == sbrg_pkg::ADDR_DIV_HIGH)  ? {24'h0, divh_q} :
                            (a8 == sbrg_pkg::ADDR_DIV_LOW)   ? {24'h0, divl_q} :
                            (a8 == sbrg_pkg::ADDR_STATUS)    ? {31'h0, vote_level} :
                            32'h0;

    // Bus slave: zero wait states, writes land at the end of the data phase
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q   <= 32'h0;
        end else begin
            wr_pend_q <= take_wr;
            wr_addr_q <= take_wr ? a8 : wr_addr_q;
            rdata_q   <= take_rd ? rd_mux : rdata_q;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_q   <= sbrg_pkg::TX_RESET;
            rx_q   <= sbrg_pkg::RX_RESET;
            rc_q   <= sbrg_pkg::RC_RESET;
            divh_q <= sbrg_pkg::DIV_RESET;
            divl_q <= sbrg_pkg::DIV_RESET;
        end else begin
            if (wr_tx) tx_q <= (wd & sbrg_pkg::TX_WMASK) | (tx_q & ~sbrg_pkg::TX_WMASK);
            if (wr_rx) rx_q <= (wd & sbrg_pkg::RX_WMASK) | (rx_q & ~sbrg_pkg::RX_WMASK);
            if (wr_rc) rc_q <= (wd & sbrg_pkg::RC_WMASK) | (rc_q & ~sbrg_pkg::RC_WMASK);
            if (wr_dh) divh_q <= wd;
            if (wr_dl) divl_q <= wd;
        end
    end

    // Rate timer: period (n+1) times prescale, all from CLK
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_cnt_q  <= 7'h00;
            div_cnt_q  <= 16'h0000;
            bit_tick_q <= 1'b0;
        end else if (div_wr || !run) begin
            pre_cnt_q  <= 7'h00;
            div_cnt_q  <= 16'h0000;
            bit_tick_q <= 1'b0;
        end else begin
            bit_tick_q <= pre_end & div_end;
            if (pre_end) begin
                pre_cnt_q <= 7'h00;
                div_cnt_q <= div_end ? 16'h0000 : div_cnt_q + 16'h0001;
            end else begin
                pre_cnt_q <= pre_cnt_q + 7'h01;
            end
        end
    end

    // Sampling: three consecutive sample points per bit, in every mode
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            smp_cnt_q     <= 2'h0;
            sample_tick_q <= 1'b0;
        end else if (div_wr || !run) begin
            smp_cnt_q     <= 2'h0;
            sample_tick_q <= 1'b0;
        end else if (smp_open || smp_cnt_q != 2'h0) begin
            smp_cnt_q     <= (smp_cnt_q == 2'(sbrg_pkg::SAMPLES - 1)) ? 2'h0 : smp_cnt_q + 2'h1;
            sample_tick_q <= 1'b1;
        end else begin
            smp_cnt_q     <= 2'h0;
            sample_tick_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= RX_PIN;
            rx_s2_q <= rx_s1_q;
        end
    end

    sbrg_vote u_vote (
        .clk       (CLK),
        .rst_n     (RST_N),
        .sample_en (sample_tick_q),
        .line_in   (rx_s2_q),
        .level_q   (vote_level)
    );

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BIT_TICK    <= 1'b0;
            SAMPLE_TICK <= 1'b0;
            RX_LEVEL    <= 1'b1;
            HREADYOUT   <= 1'b1;
            HRESP       <= 1'b0;
        end else begin
            BIT_TICK    <= bit_tick_q;
            SAMPLE_TICK <= sample_tick_q;
            RX_LEVEL    <= vote_level;
            HREADYOUT   <= 1'b1;
            HRESP       <= 1'b0;
        end
    end
    assign HRDATA = rdata_q;

    // Tick spacing equals prescale times (n+1) in steady state
    logic [23:0] gap_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) gap_q <= 24'h0;
        else if (bit_tick_q || div_wr || !run) gap_q <= 24'h0;
        else gap_q <= gap_q + 24'h1;
    end
    logic stable_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) stable_q <= 1'b0;
        else if (div_wr || wr_tx || wr_rc || !run) stable_q <= 1'b0;
        else if (bit_tick_q) stable_q <= 1'b1;
    end
    wire [23:0] period = 24'(pre_sel) * 24'({8'h00, divisor} + 24'h1);

    a_tick_period: assert property (@(posedge CLK) disable iff (!RST_N)
        (bit_tick_q && stable_q && $past(stable_q) && !$past(wr_tx) && !$past(wr_rc))
            |-> (gap_q + 24'h1 == period))
        else $error("bit tick period wrong");
    a_write_clears: assert property (@(posedge CLK) disable iff (!RST_N)
        div_wr |=> (div_cnt_q == 16'h0 && pre_cnt_q == 7'h0 && !bit_tick_q))
        else $error("divisor write did not clear timer");
    a_sync_prescale: assert property (@(posedge CLK) disable iff (!RST_N)
        sync_md |-> pre_sel == sbrg_pkg::PRE_4)
        else $error("sync prescale wrong");
    a_async_fast_wide: assert property (@(posedge CLK) disable iff (!RST_N)
        (!sync_md && wide && hspeed) |-> pre_sel == sbrg_pkg::PRE_4)
        else $error("wide fast prescale wrong");
    a_async_fast_narrow: assert property (@(posedge CLK) disable iff (!RST_N)
        (!sync_md && !wide && hspeed) |-> pre_sel == sbrg_pkg::PRE_16)
        else $error("narrow fast prescale wrong");
    a_async_slow_wide: assert property (@(posedge CLK) disable iff (!RST_N)
        (!sync_md && wide && !hspeed) |-> pre_sel == sbrg_pkg::PRE_16)
        else $error("wide slow prescale wrong");
    a_narrow_divisor: assert property (@(posedge CLK) disable iff (!RST_N)
        !wide |-> divisor[15:8] == 8'h00 && divisor[7:0] == divl_q)
        else $error("high byte used in narrow mode");
    sequence s_three_same;
        (sample_tick_q && rx_s2_q == 1'b0) ##1 (sample_tick_q && rx_s2_q == 1'b0)
            ##1 (sample_tick_q && rx_s2_q == 1'b0);
    endsequence
    a_vote_low: assert property (@(posedge CLK) disable iff (!RST_N)
        s_three_same |=> !vote_level)
        else $error("majority of lows not low");
    a_reset_narrow: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(wide) |-> $past(wr_rc))
        else $error("width changed without write");
    sequence s_sample_burst;
        sample_tick_q ##1 sample_tick_q ##1 sample_tick_q ##1 !sample_tick_q;
    endsequence
    a_sample_burst: assert property (@(posedge CLK) disable iff (!RST_N || div_wr || !run)
        (smp_open && smp_cnt_q == 2'h0) |=> s_sample_burst)
        else $error("sample burst not three ticks");
endmodule : sbrg_top

/* sbrg_pkg.sv */
package sbrg_pkg;
    // Register byte addresses on the AHB-Lite slave
    localparam logic [7:0] ADDR_TX_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_RX_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_RATE_CTRL = 8'h08;
    localparam logic [7:0] ADDR_DIV_HIGH  = 8'h0C;
    localparam logic [7:0] ADDR_DIV_LOW   = 8'h10;
    localparam logic [7:0] ADDR_STATUS    = 8'h14;
    // Field positions
    localparam int TX_SYNC_BIT   = 4;
    localparam int TX_HSPEED_BIT = 2;
    localparam int RC_WIDTH_BIT  = 3;
    localparam int RX_SPEN_BIT   = 7;
    // Writable masks and reset values
    localparam logic [7:0] TX_WMASK   = 8'hFD;
    localparam logic [7:0] TX_RESET   = 8'h02;
    localparam logic [7:0] RX_WMASK   = 8'hF8;
    localparam logic [7:0] RX_RESET   = 8'h00;
    localparam logic [7:0] RC_WMASK   = 8'h1B;
    localparam logic [7:0] RC_RESET   = 8'h40;
    localparam logic [7:0] DIV_RESET  = 8'h00;
    // Prescale: clock cycles per bit per unit of (n+1)
    localparam logic [6:0] PRE_64 = 7'h40;
    localparam logic [6:0] PRE_16 = 7'h10;
    localparam logic [6:0] PRE_4  = 7'h04;
    // Samples for the majority vote, taken on three consecutive clocks from the middle prescale period
    localparam int          SAMPLES   = 3;
    localparam logic [3:0]  SAMPLE_0  = 4'h7;
endpackage : sbrg_pkg

/* sbrg_vote.sv */
`timescale 1ns/1ps
module sbrg_vote (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sample_en,
    input  wire logic       line_in,
    output logic            level_q
);
    logic [2:0] hist_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_q  <= 3'h7;
            level_q <= 1'b1;
        end else if (sample_en) begin
            hist_q  <= {hist_q[1:0], line_in};
            // Two of three decide the level
            level_q <= (hist_q[1] & hist_q[0]) | (hist_q[1] & line_in) | (hist_q[0] & line_in);
        end
    end
endmodule : sbrg_vote

/* sbrg_line_model.sv */
`timescale 1ns/1ps
module sbrg_line_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic level,
    input  wire logic glitch_en,
    output logic      line
);
    logic [2:0] cnt_q;
    // Spikes one cycle wide, seven apart, so three close samples see one at most
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 3'h0;
        else cnt_q <= (cnt_q == 3'h6) ? 3'h0 : cnt_q + 3'h1;
    end
    assign line = (glitch_en && cnt_q == 3'h0) ? ~level : level;
endmodule : sbrg_line_model

/* sbrg_top_tb_top.sv */
`timescale 1ns/1ps
module sbrg_top_tb_top;
    logic        CLK, RST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
    logic        RX_PIN, BIT_TICK, SAMPLE_TICK, RX_LEVEL, rx_level, glitch_en;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE, md;
    int          mismatches, num_checks, cycles, gap, smp, p, n;
    logic [2:0]  modes [8] = '{3'b000, 3'b010, 3'b001, 3'b011, 3'b100, 3'b110, 3'b101, 3'b111};
    logic [7:0]  raddr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [7:0]  rrst  [6] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h01};
    assign HREADY = HREADYOUT;
    sbrg_top u_sbrg_top (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_PIN(RX_PIN), .BIT_TICK(BIT_TICK),
        .SAMPLE_TICK(SAMPLE_TICK), .RX_LEVEL(RX_LEVEL));
    sbrg_line_model u_sbrg_line_model (.clk(CLK), .rst_n(RST_N), .level(rx_level),
        .glitch_en(glitch_en), .line(RX_PIN));
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    // Whole run needs about 25000 cycles
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_win(input int got, input int exp);
        num_checks++;
        if (got < exp - 2 || got > exp + 4) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_win
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CLK);
        HSEL <= 1'b1; HADDR <= {24'h0, a}; HTRANS <= 2'h2; HWRITE <= wr; HSIZE <= 3'h2;
        @(posedge CLK);
        while (HREADY !== 1'b1) @(posedge CLK);
        HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= wd;
        @(posedge CLK);
        while (HREADY !== 1'b1) @(posedge CLK);
        rd = HRDATA;
        chk({31'h0, HRESP}, 32'h0);
    endtask : ahb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk
    task automatic next_tick(output int cnt, output int nsmp);
        cnt = 0;
        nsmp = 0;
        do begin
            @(negedge CLK);
            cnt++;
            if (SAMPLE_TICK === 1'b1) nsmp++;
        end while (BIT_TICK !== 1'b1 && cnt < 20000);
    endtask : next_tick
    task automatic hold_chk(input logic lvl);
        int bad;
        bad = 0;
        rx_level <= lvl;
        repeat (150) @(negedge CLK);
        repeat (300) begin
            @(negedge CLK);
            if (RX_LEVEL !== lvl) bad++;
        end
        chk(bad, 0);
        rd_chk(sbrg_pkg::ADDR_STATUS, {31'h0, lvl});
    endtask : hold_chk
    initial begin
        RST_N = 1'b0; HSEL = 1'b0; HADDR = 32'h0; HTRANS = 2'h0; HWRITE = 1'b0; HSIZE = 3'h2;
        HWDATA = 32'h0; rx_level = 1'b1; glitch_en = 1'b0;
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 6; i++) rd_chk(raddr[i], {24'h0, rrst[i]});
        ahb(1'b1, sbrg_pkg::ADDR_RX_CTRL, 32'h80);
        ahb(1'b1, sbrg_pkg::ADDR_DIV_HIGH, 32'h01);
        ahb(1'b1, sbrg_pkg::ADDR_DIV_LOW, 32'h02);
        next_tick(gap, smp);
        next_tick(gap, smp);
        chk_win(gap, 192);
        chk(smp, 3);
        ahb(1'b1, sbrg_pkg::ADDR_TX_CTRL, 32'h00);
        rd_chk(sbrg_pkg::ADDR_TX_CTRL, {24'h0, sbrg_pkg::TX_RESET});
        ahb(1'b1, sbrg_pkg::ADDR_RATE_CTRL, 32'hFF);
        rd_chk(sbrg_pkg::ADDR_RATE_CTRL, {24'h0, sbrg_pkg::RC_WMASK | sbrg_pkg::RC_RESET});
        ahb(1'b1, 8'h18, 32'hFF);
        rd_chk(8'h18, 32'h0);
        foreach (modes[i]) begin
            md = modes[i];
            p = md[2] ? 4 : (md[0] ? (md[1] ? 4 : 16) : (md[1] ? 16 : 64));
            n = md[0] ? 258 : 2;
            ahb(1'b1, sbrg_pkg::ADDR_TX_CTRL, {27'h0, md[2], 1'b0, md[1], 2'h0});
            ahb(1'b1, sbrg_pkg::ADDR_RATE_CTRL, {28'h0, md[0], 3'h0});
            next_tick(gap, smp);
            next_tick(gap, smp);
            chk_win(gap, p * (n + 1));
            chk(smp, 3);
        end
        // Async 16-bit low speed, divisor 258, then shrink it mid-count
        ahb(1'b1, sbrg_pkg::ADDR_TX_CTRL, 32'h00);
        ahb(1'b1, sbrg_pkg::ADDR_RATE_CTRL, 32'h08);
        next_tick(gap, smp);
        repeat (2000) @(negedge CLK);
        ahb(1'b1, sbrg_pkg::ADDR_DIV_HIGH, 32'h00);
        next_tick(gap, smp);
        chk_win(gap, 48);
        repeat (30) @(negedge CLK);
        ahb(1'b1, sbrg_pkg::ADDR_DIV_LOW, 32'h00);
        next_tick(gap, smp);
        chk_win(gap, 16);
        chk(smp, 3);
        ahb(1'b1, sbrg_pkg::ADDR_DIV_LOW, 32'h02);
        glitch_en <= 1'b1;
        hold_chk(1'b0);
        hold_chk(1'b1);
        // Reset in mid-run must fall back to the 8-bit divisor
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        rd_chk(sbrg_pkg::ADDR_RATE_CTRL, {24'h0, sbrg_pkg::RC_RESET});
        finish_test();
    end
endmodule : sbrg_top_tb_top
